// *** cc_port_attach.sv ***
/*
 * Attach state machine for one reversible-connector port: DFP audio and
 * cable-supply states, UFP attach states, fault handling and debounce.
 * Assumes CC codes, mode selection and monitor compares come from
 * analog front ends outside the clock domain; all are synchronised here.
 */
// Summary of operation
// RULE_01 - DFP, enabled, valid config, Ra on both lines enters audio-accessory state.
// RULE_02 - Both CC lines shorted to ground are classified as two Ra terminations.
// RULE_03 - Overcurrent low in any state: outputs default, fault state, flag set.
// RULE_04 - Overcurrent released: leave fault state and resume detection.
// RULE_05 - Overvoltage above threshold: outputs default, fault state, flag set.
// RULE_06 - Overvoltage cleared: leave fault state and resume detection.
// RULE_07 - Fault flag output stays high after a fault until reset.
// RULE_08 - UFP disabled or invalid config: idle, all UFP outputs high.
// RULE_09 - UFP attach needs valid VBUS, Rp on one line, nothing on other.
// RULE_10 - UFP Rp on line 1 keeps orientation high; line 2 drives it low.
// RULE_11 - UFP attach drives exactly one capability output low per Rp class.
// RULE_12 - Supply 1 asserts on Rd line 2 with Ra line 1, until Rd gone.
// RULE_13 - Supply 2 asserts on Rd line 1 with Ra line 2, until Rd gone.
// RULE_14 - Cable supply enables are active-low open-drain, DFP modes only.
// RULE_15 - Audio detect is active high, held until an Ra is lost, DFP only.
// RULE_16 - Idle to attach transitions are debounced 100 to 200 ms.
// RULE_17 - Attach to attach or to idle transitions are debounced 10 to 20 ms.
// RULE_18 - UFP or DFP chosen at power-on and never switched afterwards.
// RULE_19 - CC classification arrives as digital codes per mode.
// RULE_20 - No valid attach after debounce returns to idle, outputs deasserted.
`timescale 1ns/1ns
`include "cc_port_regs.svh"
module cc_port_attach
    import cc_port_pkg::*;
#(
    parameter int ATTACH_DEB_CYCLES = `ATTACH_DEB_CYCLES,
    parameter int CHANGE_DEB_CYCLES = `CHANGE_DEB_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic [2:0] cfg_sel_i,
    input wire logic [1:0] cc1_code_i,
    input wire logic [1:0] cc2_code_i,
    input wire logic vbus_valid_i,
    input wire logic overcurrent_sense_n_i,
    input wire logic overvoltage_monitor_i,
    output logic power_switch_enable_o,
    output logic orientation_n_o,
    output logic cable_supply1_n_o,
    output logic cable_supply1_oe_o,
    output logic cable_supply2_n_o,
    output logic cable_supply2_oe_o,
    output logic audio_accessory_detect_o,
    output logic attach_n_o,
    output logic default_current_n_o,
    output logic medium_current_n_o,
    output logic high_current_n_o,
    output logic fault_flag_out_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic en_s;
    logic [2:0] cfg_s;
    logic [1:0] cc1_s;
    logic [1:0] cc2_s;
    logic vbus_s;
    logic oc_s;
    logic oc_n_s;
    logic ov_s;

    assign sync_in = {enable_i, cfg_sel_i, cc1_code_i, cc2_code_i, vbus_valid_i,
                      overcurrent_sense_n_i, overvoltage_monitor_i};

    input_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(sync_in),
        .reset_value_i(`SYNC_RESET_VALUE),
        .sync_o(sync_out)
    );

    assign {en_s, cfg_s, cc1_s, cc2_s, vbus_s, oc_n_s, ov_s} = sync_out;
    assign oc_s = ~oc_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        port_state_type st;
        port_state_type target;
        logic [1:0] target_code;
        logic target_flip;
        logic [`DEB_COUNT_WIDTH-1:0] count;
        logic mode_known;
        logic [1:0] settle;
        logic mode_ufp;
        logic [1:0] ufp_code;
        logic ufp_flip;
        logic oc_flag;
        logic ov_flag;
        logic fault_latched;
        logic power_switch_enable;
        logic orientation_n;
        logic cable_supply1_n;
        logic cable_supply2_n;
        logic audio_accessory_detect;
        logic attach_n;
        logic default_current_n;
        logic medium_current_n;
        logic high_current_n;
    } ctrl_type;

    ctrl_type r;
    ctrl_type next_r;

    localparam logic [`DEB_COUNT_WIDTH-1:0] ATTACH_LIMIT =
        `DEB_COUNT_WIDTH'(ATTACH_DEB_CYCLES - 1);
    localparam logic [`DEB_COUNT_WIDTH-1:0] CHANGE_LIMIT =
        `DEB_COUNT_WIDTH'(CHANGE_DEB_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Wanted state from the present inputs.
    port_state_type want;
    logic [1:0] want_code;
    logic want_flip;
    logic cfg_valid;

    always_comb begin
        want = ST_IDLE;
        want_code = `UFP_CC_NONE;
        want_flip = 1'b0;
        if (r.mode_ufp) begin
            cfg_valid = (cfg_s == `CFG_UFP); // RULE_18
        end else begin
            cfg_valid = (cfg_s == `CFG_DFP_LEGACY) || (cfg_s == `CFG_DFP_MEDIUM)
                        || (cfg_s == `CFG_DFP_HIGH);
        end
        if (en_s && cfg_valid && r.mode_known) begin
            if (!r.mode_ufp) begin
                // Codes are open, Ra or Rd; a grounded line reads as Ra.
                if (cc1_s == `DFP_CC_RA && cc2_s == `DFP_CC_RA) begin // RULE_19
                    want = ST_DFP_AUDIO; // RULE_01 RULE_02
                end else if (cc1_s == `DFP_CC_RD && cc2_s == `DFP_CC_RA) begin
                    want = ST_DFP_SUPPLY2; // RULE_13
                end else if (cc2_s == `DFP_CC_RD && cc1_s == `DFP_CC_RA) begin
                    want = ST_DFP_SUPPLY1; // RULE_12
                end else if (r.st == ST_DFP_SUPPLY1 && cc2_s == `DFP_CC_RD) begin
                    want = ST_DFP_SUPPLY1; // RULE_12
                end else if (r.st == ST_DFP_SUPPLY2 && cc1_s == `DFP_CC_RD) begin
                    want = ST_DFP_SUPPLY2; // RULE_13
                end
            end else if (vbus_s) begin
                if (cc1_s != `UFP_CC_NONE && cc2_s == `UFP_CC_NONE) begin
                    want = ST_UFP_ATTACHED; // RULE_09
                    want_code = cc1_s;
                    want_flip = 1'b0; // RULE_10
                end else if (cc2_s != `UFP_CC_NONE && cc1_s == `UFP_CC_NONE) begin
                    want = ST_UFP_ATTACHED; // RULE_09
                    want_code = cc2_s;
                    want_flip = 1'b1; // RULE_10
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    logic changed;

    always_comb begin
        next_r = r;
        changed = (want != r.st) || (want == ST_UFP_ATTACHED
                  && (want_code != r.ufp_code || want_flip != r.ufp_flip));
        // The mode is taken only once the synchroniser holds the real selection.
        if (!r.mode_known) begin
            if (r.settle == `SYNC_SETTLE_CYCLES) begin
                next_r.mode_known = 1'b1;
                next_r.mode_ufp = (cfg_s == `CFG_UFP); // RULE_18
            end else begin
                next_r.settle = r.settle + 2'h1;
            end
        end
        if (oc_s || ov_s) begin
            next_r.st = ST_FAULT; // RULE_03 RULE_05
            next_r.target = ST_IDLE;
            next_r.oc_flag = r.oc_flag | oc_s; // RULE_03
            next_r.ov_flag = r.ov_flag | ov_s; // RULE_05
            next_r.fault_latched = 1'b1; // RULE_07
            next_r.count = '0;
        end else if (r.st == ST_FAULT) begin
            next_r.st = ST_IDLE; // RULE_04 RULE_06
            next_r.count = '0;
        end else if (!changed) begin
            next_r.target = r.st;
            next_r.target_code = r.ufp_code;
            next_r.target_flip = r.ufp_flip;
            next_r.count = '0;
        end else if (want != r.target || want_code != r.target_code
                     || want_flip != r.target_flip) begin
            next_r.target = want;
            next_r.target_code = want_code;
            next_r.target_flip = want_flip;
            next_r.count = '0;
        end else if ((r.st == ST_IDLE && r.count == ATTACH_LIMIT) // RULE_16
                     || (r.st != ST_IDLE && r.count == CHANGE_LIMIT)) begin // RULE_17
            next_r.st = want; // RULE_20
            next_r.ufp_code = want_code;
            next_r.ufp_flip = want_flip;
            next_r.count = '0;
        end else begin
            next_r.count = r.count + `DEB_COUNT_WIDTH'(1);
        end

        // Outputs follow the state; fault and idle give defaults.
        next_r.power_switch_enable = 1'b0;
        next_r.orientation_n = 1'b1;
        next_r.cable_supply1_n = 1'b1;
        next_r.cable_supply2_n = 1'b1;
        next_r.audio_accessory_detect = 1'b0;
        next_r.attach_n = 1'b1; // RULE_08
        next_r.default_current_n = 1'b1;
        next_r.medium_current_n = 1'b1;
        next_r.high_current_n = 1'b1;
        case (next_r.st)
            ST_DFP_AUDIO: begin
                next_r.audio_accessory_detect = 1'b1; // RULE_15
            end
            ST_DFP_SUPPLY1: begin
                next_r.power_switch_enable = 1'b1;
                next_r.orientation_n = 1'b0;
                next_r.cable_supply1_n = 1'b0; // RULE_12 RULE_14
            end
            ST_DFP_SUPPLY2: begin
                next_r.power_switch_enable = 1'b1;
                next_r.cable_supply2_n = 1'b0; // RULE_13 RULE_14
            end
            ST_UFP_ATTACHED: begin
                next_r.attach_n = 1'b0; // RULE_09
                next_r.orientation_n = ~next_r.ufp_flip; // RULE_10
                next_r.default_current_n = (next_r.ufp_code != `UFP_CC_LEGACY); // RULE_11
                next_r.medium_current_n = (next_r.ufp_code != `UFP_CC_MEDIUM); // RULE_11
                next_r.high_current_n = (next_r.ufp_code != `UFP_CC_HIGH); // RULE_11
            end
            default: begin
                next_r.attach_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r <= '{st: ST_IDLE, target: ST_IDLE, target_code: 2'h0, target_flip: 1'b0,
                   count: '0, mode_known: 1'b0, settle: 2'h0, mode_ufp: 1'b0, ufp_code: 2'h0,
                   ufp_flip: 1'b0, oc_flag: 1'b0, ov_flag: 1'b0, fault_latched: 1'b0,
                   power_switch_enable: 1'b0, orientation_n: 1'b1,
                   cable_supply1_n: 1'b1, cable_supply2_n: 1'b1,
                   audio_accessory_detect: 1'b0, attach_n: 1'b1,
                   default_current_n: 1'b1, medium_current_n: 1'b1,
                   high_current_n: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops, except the cable supply data pins, tied low.
    assign power_switch_enable_o = r.power_switch_enable;
    assign orientation_n_o = r.orientation_n;
    assign cable_supply1_n_o = 1'b0;
    assign cable_supply1_oe_o = ~r.cable_supply1_n; // RULE_14
    assign cable_supply2_n_o = 1'b0;
    assign cable_supply2_oe_o = ~r.cable_supply2_n; // RULE_14
    assign audio_accessory_detect_o = r.audio_accessory_detect;
    assign attach_n_o = r.attach_n;
    assign default_current_n_o = r.default_current_n;
    assign medium_current_n_o = r.medium_current_n;
    assign high_current_n_o = r.high_current_n;
    assign fault_flag_out_o = r.fault_latched; // RULE_07
endmodule : cc_port_attach

// *** cc_port_regs.svh ***
/*
 * Timing and code constants for the CC port attach logic.
 * Assumes a 100 MHz clock; included by the attach module only.
 */
`ifndef CC_PORT_REGS_SVH
`define CC_PORT_REGS_SVH

`define CLK_PERIOD_NS 10
`define ATTACH_DEB_MIN_MS 100
`define ATTACH_DEB_MAX_MS 200
`define CHANGE_DEB_MIN_MS 10
`define CHANGE_DEB_MAX_MS 20
`define NS_PER_MS 1000000
`define ATTACH_DEB_CYCLES ((`ATTACH_DEB_MIN_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHANGE_DEB_CYCLES ((`CHANGE_DEB_MIN_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEB_COUNT_WIDTH 25
`define SYNC_SETTLE_CYCLES 2'h2
`define SYNC_RESET_VALUE 11'h002

`define DFP_CC_OPEN 2'h0
`define DFP_CC_RA 2'h1
`define DFP_CC_RD 2'h2
`define UFP_CC_NONE 2'h0
`define UFP_CC_LEGACY 2'h1
`define UFP_CC_MEDIUM 2'h2
`define UFP_CC_HIGH 2'h3

`define CFG_INVALID 3'h0
`define CFG_DFP_LEGACY 3'h1
`define CFG_DFP_MEDIUM 3'h2
`define CFG_DFP_HIGH 3'h3
`define CFG_UFP 3'h4

`endif

// *** cc_port_pkg.sv ***
/*
 * Types shared by the CC port attach logic.
 * Assumes the constants header is on the include path.
 */
package cc_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DFP_AUDIO,
        ST_DFP_SUPPLY1,
        ST_DFP_SUPPLY2,
        ST_UFP_ATTACHED,
        ST_FAULT
    } port_state_type;

endpackage : cc_port_pkg

// *** input_sync.sv ***
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs are quasi-static levels from outside the clock domain.
 */
`timescale 1ns/1ns
module input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_value_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    always_comb begin
        next_state.first = async_i;
        next_state.second = state.first;
    end

    // Reset loads the caller's idle levels so that no false event follows reset.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= '{first: reset_value_i, second: reset_value_i};
        end else begin
            state <= next_state;
        end
    end

    assign sync_o = state.second;
endmodule : input_sync

// *** cc_port_attach_checker.sv ***
/* Assertions on the ports of the CC port attach block.
   Bound to cc_port_attach from the testbench top file. */
`timescale 1ns/1ns
module cc_port_attach_checker #(
    parameter int ATTACH_DEB_CYCLES = 20,
    parameter int CHANGE_DEB_CYCLES = 5
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic [2:0] cfg_sel_i,
    input wire logic [1:0] cc1_code_i,
    input wire logic [1:0] cc2_code_i,
    input wire logic vbus_valid_i,
    input wire logic overcurrent_sense_n_i,
    input wire logic overvoltage_monitor_i,
    input wire logic power_switch_enable_o,
    input wire logic orientation_n_o,
    input wire logic cable_supply1_n_o,
    input wire logic cable_supply1_oe_o,
    input wire logic cable_supply2_n_o,
    input wire logic cable_supply2_oe_o,
    input wire logic audio_accessory_detect_o,
    input wire logic attach_n_o,
    input wire logic default_current_n_o,
    input wire logic medium_current_n_o,
    input wire logic high_current_n_o,
    input wire logic fault_flag_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_fault_outputs: assert property (
        (!overcurrent_sense_n_i || overvoltage_monitor_i)[*4] |-> fault_flag_out_o && attach_n_o
        && !audio_accessory_detect_o && !power_switch_enable_o && !cable_supply1_oe_o)
        else $error("fault outputs");
    a_flag_sticky: assert property (fault_flag_out_o |=> fault_flag_out_o)
        else $error("fault flag dropped");
    a_one_class: assert property (
        !attach_n_o |-> $onehot(~{default_current_n_o, medium_current_n_o, high_current_n_o}))
        else $error("class outputs");
    a_idle_classes: assert property (
        attach_n_o |-> &{default_current_n_o, medium_current_n_o, high_current_n_o})
        else $error("idle class outputs");
    a_audio_levels: assert property (
        audio_accessory_detect_o |-> !power_switch_enable_o && orientation_n_o
        && !cable_supply1_oe_o && !cable_supply2_oe_o) else $error("audio outputs");
    a_supply_pins: assert property (
        !cable_supply1_n_o && !cable_supply2_n_o && !(cable_supply1_oe_o && cable_supply2_oe_o)
        && (!(cable_supply1_oe_o || cable_supply2_oe_o) || attach_n_o)) else $error("supply pins");
    a_attach_cause: assert property (
        $fell(attach_n_o) |-> $past(vbus_valid_i, 4) && $past(enable_i, 4)
        && (($past(cc1_code_i, 4) == 2'h0) != ($past(cc2_code_i, 4) == 2'h0))
        && $past(cc1_code_i, 12) == $past(cc1_code_i, 4)) else $error("attach cause");
    a_attach_orient: assert property (
        $fell(attach_n_o) |-> orientation_n_o == ($past(cc2_code_i, 4) == 2'h0))
        else $error("orientation");
    c_audio: cover property ($rose(audio_accessory_detect_o));
    c_attach: cover property ($fell(attach_n_o));
    c_fault: cover property ($rose(fault_flag_out_o));
endmodule : cc_port_attach_checker

// *** cc_partner.sv ***
/* Cable or port partner driving CC codes and VBUS status.
   Adds contact bounce of bounce_i cycles after each plug change. */
`timescale 1ns/1ns
module cc_partner (
    input wire logic clk_i,
    input wire logic [1:0] plug1_i,
    input wire logic [1:0] plug2_i,
    input wire logic vbus_i,
    input wire logic [3:0] bounce_i,
    output logic [1:0] cc1_code_o,
    output logic [1:0] cc2_code_o,
    output logic vbus_valid_o
);
    logic [3:0] left = 4'h0;
    logic [4:0] last = 5'h0;
    initial {cc1_code_o, cc2_code_o, vbus_valid_o} = 5'h0;
    always @(posedge clk_i) begin
        if ({plug1_i, plug2_i, vbus_i} != last) begin
            last <= {plug1_i, plug2_i, vbus_i};
            left <= bounce_i;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
        // Bounce alternates between the new terminations and an open line.
        {cc1_code_o, cc2_code_o, vbus_valid_o} <= left[0] ? 5'h0 : last;
    end
endmodule : cc_partner

// *** tb_cc_port_attach.sv ***
/* Self-checking bench for cc_port_attach with a partner model.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/1ns
module tb_cc_port_attach;
    localparam int AD = 20;
    localparam int CD = 5;
    typedef struct packed {
        logic [2:0] cfg;
        logic [1:0] c1;
        logic [1:0] c2;
        logic vb;
        logic [9:0] exp;
    } row_type;
    logic clk_i = 0, rstn_i = 0, enable_i = 1, vbus_valid_i, vbus = 0;
    logic overcurrent_sense_n_i = 1, overvoltage_monitor_i = 0;
    logic [2:0] cfg_sel_i = 3'h4, cur = 3'h7;
    logic [1:0] cc1_code_i, cc2_code_i, plug1 = 2'h0, plug2 = 2'h0;
    logic [3:0] bounce = 4'h3;
    logic power_switch_enable_o, orientation_n_o, cable_supply1_n_o, cable_supply1_oe_o;
    logic cable_supply2_n_o, cable_supply2_oe_o, audio_accessory_detect_o, attach_n_o;
    logic default_current_n_o, medium_current_n_o, high_current_n_o, fault_flag_out_o;
    int failures = 0, check_count = 0;
    wire logic [9:0] outs = {fault_flag_out_o, power_switch_enable_o, orientation_n_o,
        cable_supply1_oe_o, cable_supply2_oe_o, audio_accessory_detect_o, attach_n_o,
        default_current_n_o, medium_current_n_o, high_current_n_o};
    row_type rows [12] = '{
        '{3'h1, 2'h1, 2'h1, 1'b0, 10'h09f},
        '{3'h2, 2'h1, 2'h2, 1'b0, 10'h14f},
        '{3'h3, 2'h2, 2'h1, 1'b0, 10'h1af},
        '{3'h3, 2'h2, 2'h0, 1'b0, 10'h08f},
        '{3'h4, 2'h1, 2'h0, 1'b1, 10'h083},
        '{3'h4, 2'h2, 2'h0, 1'b1, 10'h085},
        '{3'h4, 2'h3, 2'h0, 1'b1, 10'h086},
        '{3'h4, 2'h0, 2'h1, 1'b1, 10'h003},
        '{3'h4, 2'h0, 2'h2, 1'b1, 10'h005},
        '{3'h4, 2'h0, 2'h3, 1'b1, 10'h006},
        '{3'h4, 2'h1, 2'h0, 1'b0, 10'h08f},
        '{3'h4, 2'h2, 2'h3, 1'b1, 10'h08f}};
    always #5 clk_i = ~clk_i;
    cc_port_attach #(.ATTACH_DEB_CYCLES(AD), .CHANGE_DEB_CYCLES(CD)) dut_u (.*);
    cc_partner partner_u (.clk_i(clk_i), .plug1_i(plug1), .plug2_i(plug2), .vbus_i(vbus),
        .bounce_i(bounce), .cc1_code_o(cc1_code_i), .cc2_code_o(cc2_code_i),
        .vbus_valid_o(vbus_valid_i));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task rst(input logic [2:0] cfg);
        rstn_i = 0;
        cfg_sel_i = cfg;
        repeat (12) @(negedge clk_i);
        check("reset levels", outs, 10'h08f);
        rstn_i = 1;
        repeat (4) @(negedge clk_i);
    endtask : rst
    task plug(input logic [1:0] a, input logic [1:0] b, input logic v, input int n);
        plug1 = a;
        plug2 = b;
        vbus = v;
        repeat (n) @(negedge clk_i);
    endtask : plug
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        @(negedge clk_i);
        foreach (rows[i]) begin
            if (rows[i].cfg != cur) rst(rows[i].cfg);
            cur = rows[i].cfg;
            plug(2'h0, 2'h0, 1'b0, 3 * CD);
            plug(rows[i].c1, rows[i].c2, rows[i].vb, 2 * AD);
            check("row outputs", outs, rows[i].exp);
        end
        bounce = 4'h0;
        plug(2'h0, 2'h0, 1'b1, 3 * CD);
        plug(2'h2, 2'h0, 1'b1, AD - 5);
        plug(2'h0, 2'h0, 1'b1, 10);
        check("short attach", outs, 10'h08f);
        plug(2'h2, 2'h0, 1'b1, 2 * AD);
        plug(2'h3, 2'h0, 1'b1, CD - 2);
        check("change held", outs, 10'h085);
        plug(2'h3, 2'h0, 1'b1, 2 * CD);
        check("class change", outs, 10'h086);
        overcurrent_sense_n_i = 0;
        repeat (4) @(negedge clk_i);
        check("overcurrent", outs, 10'h28f);
        overcurrent_sense_n_i = 1;
        repeat (2 * AD) @(negedge clk_i);
        check("after overcurrent", outs, 10'h286);
        overvoltage_monitor_i = 1;
        repeat (4) @(negedge clk_i);
        check("overvoltage", outs, 10'h28f);
        overvoltage_monitor_i = 0;
        repeat (2 * AD) @(negedge clk_i);
        check("after overvoltage", outs, 10'h286);
        enable_i = 0;
        repeat (3 * CD) @(negedge clk_i);
        check("disabled", outs, 10'h28f);
        enable_i = 1;
        cfg_sel_i = 3'h1;
        plug(2'h1, 2'h1, 1'b1, 2 * AD);
        check("mode locked", outs, 10'h28f);
        rst(3'h2);
        plug(2'h1, 2'h2, 1'b0, 2 * AD);
        check("supply on", outs, 10'h14f);
        plug(2'h0, 2'h2, 1'b0, 2 * CD);
        check("supply held", outs, 10'h14f);
        plug(2'h0, 2'h0, 1'b0, 3 * CD);
        check("supply off", outs, 10'h08f);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        finish_test();
    end
endmodule : tb_cc_port_attach
bind cc_port_attach cc_port_attach_checker #(.ATTACH_DEB_CYCLES(ATTACH_DEB_CYCLES),
    .CHANGE_DEB_CYCLES(CHANGE_DEB_CYCLES)) checker_u (.*);
